// *** core/flash_sequencer.sv ***
// Flash command sequencer with APB register file
// Contract
// R01: One-hot five-bit command decode; others fail
// R02: Address from top:high:low; data via data register
// R03: High/low registers hold address bits 15..0
// R04: Data register returns read byte, holds write
// R05: Erase whole sector chosen by upper bits
// R06: Check main erase/write against protection bounds
// R07: Protected target: no array access, fail set
// R08: Refuse information write in manufacturer range
// R09: Manufacturer fuse area readable, never modified normally
// R10: Fuse modification only in writer mode
// R11: Timing base is clock times (scaler+1)/256
// R12: Software sets scaler for about 2MHz
// R13: Command resets 0x80; data, addresses zero
// R14: Scaler resets to 0x25
// R15: Fail kept on read, cleared by new command
// R16: Timeout after selected count of base periods
// R17: Address bit 16 from top address register
// R18: Bounds count 512-byte blocks, low and high
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module flash_sequencer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic writer_mode,
  output logic arr_req,
  output logic [1:0] arr_op,
  output logic arr_info,
  output logic [16:0] arr_addr,
  output logic [7:0] arr_wdata,
  input wire logic [7:0] arr_rdata,
  input wire logic arr_done
);

  timebase_if tbi ();

  flash_timebase timebase
  (
    .pclk(pclk),
    .presetn(presetn),
    .tb(tbi.source)
  );

  flash_seq_pkg::seq_state_type state_reg;
  flash_seq_pkg::seq_state_type state_next;
  logic [7:0] command_reg;
  logic [7:0] command_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] addr_high_reg;
  logic [7:0] addr_high_next;
  logic [7:0] addr_low_reg;
  logic [7:0] addr_low_next;
  logic [0:0] addr_top_reg;
  logic [0:0] addr_top_next;
  logic [7:0] scaler_reg;
  logic [7:0] scaler_next;
  logic [7:0] low_bound_reg;
  logic [7:0] low_bound_next;
  logic [7:0] high_bound_reg;
  logic [7:0] high_bound_next;
  logic [2:0] timeout_select_reg;
  logic [2:0] timeout_select_next;
  logic fail_reg;
  logic fail_next;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic arr_req_reg;
  logic arr_req_next;
  logic [1:0] arr_op_reg;
  logic [1:0] arr_op_next;
  logic arr_info_reg;
  logic arr_info_next;
  logic [13:0] limit_reg;
  logic [13:0] limit_next;
  logic [13:0] count_reg;
  logic [13:0] count_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic [15:0] index;
  logic access;
  logic reg_write;
  logic idle_write;
  logic hit;
  logic [7:0] rd_value;
  logic [4:0] code;
  logic [16:0] target;
  logic [7:0] block;
  logic protect_hit;
  logic mfg_hit;
  logic refuse;
  logic ev_done;
  logic ev_fail;

  // ==========================================================================
  // APB decode and read mux
  // ==========================================================================
  assign index = paddr[17:2];
  assign access = psel & penable;
  assign reg_write = access & pwrite;
  assign idle_write = reg_write & (state_reg == flash_seq_pkg::ST_IDLE);
  assign pready = access;
  assign pslverr = access & ~hit;

  always_comb
  begin
    hit = 1'b1;
    rd_value = 8'h00;
    case (index)
      flash_seq_pkg::IDX_COMMAND: rd_value = command_reg;
      flash_seq_pkg::IDX_DATA: rd_value = data_reg; // see R04
      flash_seq_pkg::IDX_ADDR_HIGH: rd_value = addr_high_reg; // see R03
      flash_seq_pkg::IDX_ADDR_LOW: rd_value = addr_low_reg; // see R03
      flash_seq_pkg::IDX_SCALER: rd_value = scaler_reg;
      flash_seq_pkg::IDX_ADDR_TOP: rd_value = {7'h00, addr_top_reg};
      flash_seq_pkg::IDX_LOW_BOUND: rd_value = low_bound_reg;
      flash_seq_pkg::IDX_HIGH_BOUND: rd_value = high_bound_reg;
      flash_seq_pkg::IDX_STATUS:
      begin
        rd_value = {5'h00, timeout_select_reg};
        rd_value[flash_seq_pkg::STATUS_FAIL_BIT] = fail_reg; // see R15
        rd_value[flash_seq_pkg::STATUS_BUSY_BIT] = (state_reg == flash_seq_pkg::ST_RUN);
      end
      flash_seq_pkg::IDX_IRQ_STATUS: rd_value = {6'h00, irq_status_reg};
      flash_seq_pkg::IDX_IRQ_MASK: rd_value = {6'h00, irq_mask_reg};
      default: hit = 1'b0;
    endcase
    prdata_next = (psel & ~penable) ? {24'h000000, rd_value} : prdata_reg;
  end

  // ==========================================================================
  // Command check
  // ==========================================================================
  assign code = pwdata[flash_seq_pkg::CODE_LSB +: 5];
  assign target = {addr_top_reg, addr_high_reg, addr_low_reg}; // see R02, R17
  assign block = target[flash_seq_pkg::FLASH_ADDR_MSB:flash_seq_pkg::BLOCK_LSB];
  assign protect_hit = (block < low_bound_reg) | (block > high_bound_reg); // see R06, R18
  assign mfg_hit = (addr_low_reg >= flash_seq_pkg::MFG_RANGE_START) & ~writer_mode; // see R09, R10

  always_comb
  begin
    refuse = 1'b0;
    arr_op_next = arr_op_reg;
    arr_info_next = arr_info_reg;
    limit_next = limit_reg;
    case (code) // see R01
      flash_seq_pkg::CODE_MAIN_READ:
      begin
        arr_op_next = flash_seq_pkg::OP_READ;
        arr_info_next = 1'b0;
        limit_next = flash_seq_pkg::WRITE_TIMEOUT[timeout_select_reg];
      end
      flash_seq_pkg::CODE_MAIN_ERASE:
      begin
        refuse = protect_hit; // see R07
        arr_op_next = flash_seq_pkg::OP_ERASE;
        arr_info_next = 1'b0;
        limit_next = flash_seq_pkg::ERASE_TIMEOUT[timeout_select_reg];
      end
      flash_seq_pkg::CODE_MAIN_WRITE:
      begin
        refuse = protect_hit; // see R07
        arr_op_next = flash_seq_pkg::OP_WRITE;
        arr_info_next = 1'b0;
        limit_next = flash_seq_pkg::WRITE_TIMEOUT[timeout_select_reg];
      end
      flash_seq_pkg::CODE_INFO_READ:
      begin
        arr_op_next = flash_seq_pkg::OP_READ;
        arr_info_next = 1'b1;
        limit_next = flash_seq_pkg::WRITE_TIMEOUT[timeout_select_reg];
      end
      flash_seq_pkg::CODE_INFO_WRITE:
      begin
        refuse = mfg_hit; // see R08
        arr_op_next = flash_seq_pkg::OP_WRITE;
        arr_info_next = 1'b1;
        limit_next = flash_seq_pkg::WRITE_TIMEOUT[timeout_select_reg];
      end
      default: refuse = 1'b1;
    endcase
  end

  // ==========================================================================
  // Sequencer and register next values
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    command_next = command_reg;
    data_next = data_reg;
    addr_high_next = addr_high_reg;
    addr_low_next = addr_low_reg;
    addr_top_next = addr_top_reg;
    scaler_next = scaler_reg;
    low_bound_next = low_bound_reg;
    high_bound_next = high_bound_reg;
    timeout_select_next = timeout_select_reg;
    fail_next = fail_reg;
    arr_req_next = arr_req_reg;
    count_next = count_reg;
    ev_done = 1'b0;
    ev_fail = 1'b0;
    if (idle_write)
    begin
      case (index)
        flash_seq_pkg::IDX_DATA: data_next = pwdata[7:0]; // see R04
        flash_seq_pkg::IDX_ADDR_HIGH: addr_high_next = pwdata[7:0]; // see R03
        flash_seq_pkg::IDX_ADDR_LOW: addr_low_next = pwdata[7:0]; // see R03
        flash_seq_pkg::IDX_ADDR_TOP: addr_top_next = pwdata[0:0]; // see R17
        flash_seq_pkg::IDX_SCALER: scaler_next = pwdata[7:0];
        flash_seq_pkg::IDX_LOW_BOUND: low_bound_next = pwdata[7:0];
        flash_seq_pkg::IDX_HIGH_BOUND: high_bound_next = pwdata[7:0];
        flash_seq_pkg::IDX_STATUS: timeout_select_next = pwdata[2:0];
        default: command_next = command_reg;
      endcase
    end
    case (state_reg)
      flash_seq_pkg::ST_IDLE:
      begin
        if (idle_write && index == flash_seq_pkg::IDX_COMMAND)
        begin
          command_next = pwdata[7:0];
          fail_next = refuse; // see R15
          count_next = 14'h0000;
          if (refuse)
          begin
            ev_done = 1'b1;
            ev_fail = 1'b1;
          end
          else
          begin
            arr_req_next = 1'b1;
            state_next = flash_seq_pkg::ST_RUN;
          end
        end
      end
      flash_seq_pkg::ST_RUN:
      begin
        if (arr_done)
        begin
          arr_req_next = 1'b0;
          ev_done = 1'b1;
          state_next = flash_seq_pkg::ST_IDLE;
          if (arr_op_reg == flash_seq_pkg::OP_READ)
          begin
            data_next = arr_rdata; // see R04
          end
        end
        else if (tbi.tick)
        begin
          count_next = count_reg + 14'h0001;
          if (count_next >= limit_reg) // see R16
          begin
            arr_req_next = 1'b0;
            fail_next = 1'b1;
            ev_done = 1'b1;
            ev_fail = 1'b1;
            state_next = flash_seq_pkg::ST_IDLE;
          end
        end
      end
      default: state_next = flash_seq_pkg::ST_IDLE;
    endcase
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    if (reg_write && index == flash_seq_pkg::IDX_IRQ_MASK)
    begin
      irq_mask_next = pwdata[1:0];
    end
    if (reg_write && index == flash_seq_pkg::IDX_IRQ_STATUS)
    begin
      irq_status_next = irq_status_reg & ~pwdata[1:0];
    end
    irq_status_next[flash_seq_pkg::IRQ_DONE_BIT] = irq_status_next[flash_seq_pkg::IRQ_DONE_BIT] | ev_done;
    irq_status_next[flash_seq_pkg::IRQ_FAIL_BIT] = irq_status_next[flash_seq_pkg::IRQ_FAIL_BIT] | ev_fail;
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= flash_seq_pkg::ST_IDLE;
      command_reg <= flash_seq_pkg::COMMAND_RESET; // see R13
      data_reg <= flash_seq_pkg::DATA_RESET; // see R13
      addr_high_reg <= flash_seq_pkg::ADDR_RESET; // see R13
      addr_low_reg <= flash_seq_pkg::ADDR_RESET; // see R13
      addr_top_reg <= flash_seq_pkg::ADDR_TOP_RESET; // see R17
      scaler_reg <= flash_seq_pkg::SCALER_RESET; // see R14
      low_bound_reg <= flash_seq_pkg::LOW_BOUND_RESET;
      high_bound_reg <= flash_seq_pkg::HIGH_BOUND_RESET;
      timeout_select_reg <= flash_seq_pkg::TIMEOUT_SELECT_RESET;
      fail_reg <= 1'b0;
      irq_status_reg <= flash_seq_pkg::IRQ_RESET;
      irq_mask_reg <= flash_seq_pkg::IRQ_RESET;
      arr_req_reg <= 1'b0;
      arr_op_reg <= flash_seq_pkg::OP_READ;
      arr_info_reg <= 1'b0;
      limit_reg <= 14'h0000;
      count_reg <= 14'h0000;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      command_reg <= command_next;
      data_reg <= data_next;
      addr_high_reg <= addr_high_next;
      addr_low_reg <= addr_low_next;
      addr_top_reg <= addr_top_next;
      scaler_reg <= scaler_next;
      low_bound_reg <= low_bound_next;
      high_bound_reg <= high_bound_next;
      timeout_select_reg <= timeout_select_next;
      fail_reg <= fail_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      arr_req_reg <= arr_req_next;
      prdata_reg <= prdata_next;
      count_reg <= count_next;
      if (state_reg == flash_seq_pkg::ST_IDLE)
      begin
        arr_op_reg <= arr_op_next;
        arr_info_reg <= arr_info_next;
        limit_reg <= limit_next;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign tbi.scaler = scaler_reg; // see R11
  assign tbi.run = (state_reg == flash_seq_pkg::ST_RUN);
  assign prdata = prdata_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
  assign arr_req = arr_req_reg;
  assign arr_op = arr_op_reg;
  assign arr_info = arr_info_reg;
  assign arr_addr = target; // see R02, R05
  assign arr_wdata = data_reg; // see R02

endmodule

// *** core/flash_timebase.sv ***
// Timing base clock: one tick per 256/(scaler+1) system clocks
`timescale 1ns/1ps
module flash_timebase
(
  input wire logic pclk,
  input wire logic presetn,
  timebase_if.source tb
);

  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [8:0] sum;

  // ==========================================================================
  // Phase accumulator; carry out marks a tick
  // ==========================================================================
  always_comb
  begin
    sum = {1'b0, acc_reg} + {1'b0, tb.scaler} + 9'h001; // see R11
    acc_next = tb.run ? sum[7:0] : 8'h00;
    tick_next = tb.run & sum[8];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tb.tick = tick_reg;

endmodule

// *** inc/flash_seq_pkg.sv ***
// Register map, command codes and timing constants of the flash command sequencer
package flash_seq_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [15:0] IDX_COMMAND = 16'ha020;
  localparam logic [15:0] IDX_DATA = 16'ha021;
  localparam logic [15:0] IDX_ADDR_HIGH = 16'ha022;
  localparam logic [15:0] IDX_ADDR_LOW = 16'ha023;
  localparam logic [15:0] IDX_SCALER = 16'ha024;
  localparam logic [15:0] IDX_ADDR_TOP = 16'ha012;
  localparam logic [15:0] IDX_LOW_BOUND = 16'ha025;
  localparam logic [15:0] IDX_HIGH_BOUND = 16'ha026;
  localparam logic [15:0] IDX_STATUS = 16'ha030;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'ha031;
  localparam logic [15:0] IDX_IRQ_MASK = 16'ha032;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] COMMAND_RESET = 8'h80;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [0:0] ADDR_TOP_RESET = 1'h0;
  localparam logic [7:0] SCALER_RESET = 8'h25;
  localparam logic [7:0] LOW_BOUND_RESET = 8'hff;
  localparam logic [7:0] HIGH_BOUND_RESET = 8'h00;
  localparam logic [2:0] TIMEOUT_SELECT_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================================
  // Fields
  // ==========================================================================
  localparam int CODE_LSB = 3;
  localparam int STATUS_FAIL_BIT = 7;
  localparam int STATUS_BUSY_BIT = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int BLOCK_LSB = 9;
  localparam int FLASH_ADDR_MSB = 16;
  localparam logic [7:0] MFG_RANGE_START = 8'h80;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [4:0] CODE_MAIN_READ = 5'h10;
  localparam logic [4:0] CODE_MAIN_ERASE = 5'h08;
  localparam logic [4:0] CODE_MAIN_WRITE = 5'h04;
  localparam logic [4:0] CODE_INFO_READ = 5'h02;
  localparam logic [4:0] CODE_INFO_WRITE = 5'h01;

  typedef enum logic [1:0] {OP_READ = 2'b00, OP_ERASE = 2'b01, OP_WRITE = 2'b10} array_op_type;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} seq_state_type;

  // ==========================================================================
  // Timeouts in timing base clock periods, indexed by timeout_select
  // ==========================================================================
  localparam logic [13:0] WRITE_TIMEOUT [0:7] = '{14'h0037, 14'h003c, 14'h0041, 14'h0045,
                                                  14'h004b, 14'h0050, 14'h0055, 14'h0059};
  localparam logic [13:0] ERASE_TIMEOUT [0:7] = '{14'h153b, 14'h1741, 14'h1934, 14'h1af1,
                                                  14'h1cf0, 14'h1ee2, 14'h20d1, 14'h22b9};

endpackage

// *** inc/timebase_if.sv ***
// Link between the sequencer and its timing base clock generator
`timescale 1ns/1ps
interface timebase_if;
  logic [7:0] scaler;
  logic run;
  logic tick;
  modport source (input scaler, input run, output tick);
  modport sink (output scaler, output run, input tick);
endinterface

// *** verification/embedded_flash_command_sequencer_tb_top.sv ***
// Testbench of the flash command sequencer
`timescale 1ns/1ps
module automatic embedded_flash_command_sequencer_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, writer_mode = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] delay = 8'h03;
  logic [31:0] prdata;
  logic pready, pslverr, irq, arr_req, arr_info, arr_done, errv;
  logic [1:0] arr_op;
  logic [16:0] arr_addr;
  logic [7:0] arr_wdata, arr_rdata, rdv;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles;

  always #2 pclk = ~pclk;

  flash_sequencer u_flash_sequencer (.*);
  flash_array_model u_flash_array_model (.*);

  // =====
  // Bus and compare helpers
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 1; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
      miscompares++;
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    check(what, {24'h0, exp}, {24'h0, rdv});
  endtask

  task set_addr(input logic [16:0] a);
    wr(flash_seq_pkg::IDX_ADDR_TOP, {7'h00, a[16]});
    wr(flash_seq_pkg::IDX_ADDR_HIGH, a[15:8]);
    wr(flash_seq_pkg::IDX_ADDR_LOW, a[7:0]);
  endtask

  task cmd(input string what, input logic [4:0] code, input logic exp_fail);
    wr(flash_seq_pkg::IDX_COMMAND, {code, 3'b000});
    repeat (2) @(posedge pclk);
    cycles = 0;
    while (arr_req !== 1'b0 && cycles < 5000)
    begin
      @(posedge pclk);
      cycles++;
    end
    if (arr_req !== 1'b0)
      miscompares++;
    apb(flash_seq_pkg::IDX_STATUS, 1'b0, 8'h00);
    check(what, {31'h0, exp_fail}, {31'h0, rdv[flash_seq_pkg::STATUS_FAIL_BIT]});
  endtask

  function logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
  endfunction

  // =====
  // Scenarios
  task test_regs();
    logic [15:0] idx [8] = '{16'ha020, 16'ha021, 16'ha022, 16'ha023, 16'ha012, 16'ha024, 16'ha025, 16'ha026};
    logic [7:0] exp [8] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h25, 8'hff, 8'h00};
    foreach (idx[i])
      rd_chk("reset value", idx[i], exp[i]);
    set_addr(17'h0_a55a);
    rd_chk("addr high", flash_seq_pkg::IDX_ADDR_HIGH, 8'ha5);
    rd_chk("addr low", flash_seq_pkg::IDX_ADDR_LOW, 8'h5a);
    apb(16'ha0ff, 1'b0, 8'h00);
    check("unmapped", 32'h0000_0100, {23'h0, errv, rdv});
  endtask

  task test_read();
    wr(flash_seq_pkg::IDX_IRQ_MASK, 8'h03);
    wr(flash_seq_pkg::IDX_SCALER, 8'h01);
    set_addr(17'h1_2345);
    cmd("main read", flash_seq_pkg::CODE_MAIN_READ, 1'b0);
    rd_chk("read byte", flash_seq_pkg::IDX_DATA, 8'h45 ^ 8'h23 ^ 8'h01);
    check("irq done", 32'h1, {31'h0, irq});
    wr(flash_seq_pkg::IDX_IRQ_STATUS, 8'h01);
    @(posedge pclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(flash_seq_pkg::IDX_IRQ_MASK, 8'h00);
    delay <= 8'h14;
    cmd("info read", flash_seq_pkg::CODE_INFO_READ, 1'b0);
    delay <= 8'h00;
    check("irq masked", 32'h0, {31'h0, irq});
    rd_chk("info byte", flash_seq_pkg::IDX_DATA, 8'hba);
    rd_chk("irq status", flash_seq_pkg::IDX_IRQ_STATUS, 8'h01);
  endtask

  task test_protect();
    logic [16:0] adr [7] = '{17'h0_1000, 17'h0_1e00, 17'h0_2000, 17'h1_e1ff, 17'h1_e200, 17'h0_4123, 17'h0_0000};
    logic bad [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [4:0] code;
    wr(flash_seq_pkg::IDX_DATA, 8'h3c);
    foreach (adr[i])
    begin
      code = i > 4 ? flash_seq_pkg::CODE_MAIN_ERASE : flash_seq_pkg::CODE_MAIN_WRITE;
      set_addr(adr[i]);
      cmd("zone result", code, bad[i]);
      check("array byte", {24'h0, bad[i] ? pat(adr[i]) : i > 4 ? 8'hff : 8'h3c},
            {24'h0, u_flash_array_model.main_mem[adr[i]]});
      if (i == 0)
      begin
        rd_chk("fail kept", flash_seq_pkg::IDX_STATUS, 8'h80);
        wr(flash_seq_pkg::IDX_LOW_BOUND, 8'h10);
        wr(flash_seq_pkg::IDX_HIGH_BOUND, 8'hf0);
      end
    end
    check("sector start", 32'h0000_00ff, {24'h0, u_flash_array_model.main_mem[17'h0_4000]});
    check("sector end", 32'h0000_00ff, {24'h0, u_flash_array_model.main_mem[17'h0_41ff]});
    check("next sector", {24'h0, pat(17'h0_4200)}, {24'h0, u_flash_array_model.main_mem[17'h0_4200]});
  endtask

  task test_info();
    logic [7:0] lo [4] = '{8'h80, 8'hff, 8'h7f, 8'h80};
    logic bad [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    wr(flash_seq_pkg::IDX_DATA, 8'h96);
    foreach (lo[i])
    begin
      writer_mode <= i == 3;
      set_addr({9'h000, lo[i]});
      cmd("info write", flash_seq_pkg::CODE_INFO_WRITE, bad[i]);
      check("info byte", {24'h0, bad[i] ? ~lo[i] : 8'h96}, {24'h0, u_flash_array_model.info_mem[lo[i]]});
    end
    writer_mode <= 1'b0;
  endtask

  task test_codes();
    logic [4:0] codes [4] = '{5'b00011, 5'b10010, 5'b00000, 5'b11111};
    int ops = u_flash_array_model.op_count;
    foreach (codes[i])
      cmd("bad code", codes[i], 1'b1);
    check("array idle", 32'(ops), 32'(u_flash_array_model.op_count));
  endtask

  task test_timeout();
    logic [7:0] sc [3] = '{8'hff, 8'hff, 8'h7f};
    logic [2:0] sel [3] = '{3'h0, 3'h7, 3'h0};
    int lim [3] = '{55, 89, 110};
    // Array too slow; scaler 0xff ticks every clock
    delay <= 8'hff;
    foreach (sc[i])
    begin
      wr(flash_seq_pkg::IDX_SCALER, sc[i]);
      wr(flash_seq_pkg::IDX_STATUS, {5'h00, sel[i]});
      cmd("timeout fail", flash_seq_pkg::CODE_MAIN_READ, 1'b1);
      check("timeout span", 32'h1, {31'h0, cycles >= lim[i] - 3 && cycles <= lim[i] + 6});
    end
    delay <= 8'h03;
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_read();
    test_protect();
    test_info();
    test_codes();
    test_timeout();
    print_verdict();
  end
endmodule

// *** verification/flash_array_model.sv ***
// Flash array and information block model
`timescale 1ns/1ps
module flash_array_model
(
  input logic pclk,
  input logic presetn,
  input logic [7:0] delay,
  input logic arr_req,
  input logic [1:0] arr_op,
  input logic arr_info,
  input logic [16:0] arr_addr,
  input logic [7:0] arr_wdata,
  output logic [7:0] arr_rdata,
  output logic arr_done
);
  logic [7:0] main_mem [0:131071];
  logic [7:0] info_mem [0:255];
  logic [7:0] last_reg;
  logic served_reg;
  int wait_cnt;
  int op_count;

  initial
  begin
    for (int i = 0; i < 131072; i++)
      main_mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'(i >> 16);
    for (int i = 0; i < 256; i++)
      info_mem[i] = ~8'(i);
    last_reg = 8'h00;
    op_count = 0;
  end

  // Idle byte lane shows the inverse of the last byte
  assign arr_rdata = arr_done ? last_reg : ~last_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn || !arr_req)
    begin
      arr_done <= 1'b0;
      served_reg <= 1'b0;
      wait_cnt <= 0;
    end
    else if (served_reg)
      arr_done <= 1'b0;
    else if (wait_cnt < delay)
      wait_cnt <= wait_cnt + 1;
    else
    begin
      served_reg <= 1'b1;
      arr_done <= 1'b1;
      op_count <= op_count + 1;
      if (arr_op == 2'b00)
        last_reg <= arr_info ? info_mem[arr_addr[7:0]] : main_mem[arr_addr];
      else if (arr_op == 2'b01)
        for (int i = 0; i < 512; i++)
          main_mem[{arr_addr[16:9], 9'(i)}] <= 8'hff;
      else if (arr_info)
        info_mem[arr_addr[7:0]] <= arr_wdata;
      else
        main_mem[arr_addr] <= arr_wdata;
    end
  end
endmodule

// *** verification/flash_sequencer_sva.sv ***
// Assertions of the flash command sequencer
`timescale 1ns/1ps
module flash_sequencer_sva
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [17:0] paddr,
  input logic [31:0] pwdata,
  input logic writer_mode,
  input logic arr_req,
  input logic [1:0] arr_op,
  input logic arr_info,
  input logic [16:0] arr_addr,
  input logic [7:0] arr_wdata,
  input logic [7:0] arr_rdata,
  input logic arr_done
);
  localparam int REQ_LIMIT = 2275600;
  logic cmd_wr;
  logic [15:0] widx;
  logic [4:0] code, code_sh;
  logic [16:0] addr_sh;
  logic [7:0] data_sh, low_sh, high_sh;
  int req_cnt;

  // =====
  // Register shadows kept from idle writes
  assign widx = (psel && penable && pwrite && !arr_req) ? paddr[17:2] : 16'h0000;
  assign cmd_wr = widx == flash_seq_pkg::IDX_COMMAND;
  assign code = pwdata[7:3];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_sh <= 5'h10;
      addr_sh <= 17'h0_0000;
      data_sh <= 8'h00;
      low_sh <= 8'hff;
      high_sh <= 8'h00;
      req_cnt <= 0;
    end
    else
    begin
      req_cnt <= arr_req ? req_cnt + 1 : 0;
      if (arr_req && arr_done && arr_op == 2'b00)
        data_sh <= arr_rdata;
      case (widx)
        flash_seq_pkg::IDX_COMMAND: code_sh <= code;
        flash_seq_pkg::IDX_ADDR_TOP: addr_sh[16] <= pwdata[0];
        flash_seq_pkg::IDX_ADDR_HIGH: addr_sh[15:8] <= pwdata[7:0];
        flash_seq_pkg::IDX_ADDR_LOW: addr_sh[7:0] <= pwdata[7:0];
        flash_seq_pkg::IDX_DATA: data_sh <= pwdata[7:0];
        flash_seq_pkg::IDX_LOW_BOUND: low_sh <= pwdata[7:0];
        flash_seq_pkg::IDX_HIGH_BOUND: high_sh <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // =====
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  addr_map_a: assert property (arr_addr == addr_sh)
    else $error("address mismatch");
  data_map_a: assert property (arr_wdata == data_sh)
    else $error("write byte mismatch");
  read_accept_a: assert property (cmd_wr && (code == 5'h10 || code == 5'h02) |=> arr_req)
    else $error("read not started");
  bad_code_a: assert property (cmd_wr && $countones(code) != 1 |=> (!arr_req) [*2])
    else $error("bad code reached array");
  op_decode_a: assert property ($rose(arr_req) |-> arr_info == (code_sh[1] || code_sh[0]) &&
    arr_op == (code_sh[3] ? 2'b01 : (code_sh[2] || code_sh[0]) ? 2'b10 : 2'b00))
    else $error("operation mismatch");
  zone_block_a: assert property ($rose(arr_req) && !arr_info && arr_op != 2'b00 |->
    arr_addr[16:9] >= low_sh && arr_addr[16:9] <= high_sh)
    else $error("protected block modified");
  mfg_guard_a: assert property ($rose(arr_req) && arr_info && arr_op == 2'b10 |->
    arr_addr[7:0] < flash_seq_pkg::MFG_RANGE_START || writer_mode)
    else $error("manufacturer byte written");
  req_steady_a: assert property (arr_req ##1 arr_req |-> $stable({arr_op, arr_info, arr_addr, arr_wdata}))
    else $error("request changed");
  req_timeout_a: assert property (req_cnt < REQ_LIMIT)
    else $error("request outlived timeout");

  cover property ($rose(arr_req) && arr_op == 2'b01);
  cover property (arr_done && arr_info);
  cover property (cmd_wr && code == flash_seq_pkg::CODE_MAIN_WRITE ##1 !arr_req);
endmodule

bind flash_sequencer flash_sequencer_sva u_flash_sequencer_sva
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .writer_mode,
  .arr_req, .arr_op, .arr_info, .arr_addr, .arr_wdata, .arr_rdata, .arr_done
);
